/* fbsp_sram_port.sv */
// synchronous command, burst and late-write logic of an 18-bit burst sram
`timescale 1ns/1ps
module fbsp_sram_port
    import fbsp_pkg::*;
#(
    parameter int ADDR_W = 21,  // word address width
    parameter int LANE_W = 9    // bits per byte lane
) (
    input  wire logic              mclk_i,                // system clock, 200 MHz
    input  wire logic              sys_rst_i,             // synchronous reset
    input  wire logic              clock_hold_n_i,        // high: hold this edge
    input  wire logic              chip_sel0_n_i,         // chip select 0, low active
    input  wire logic              chip_sel1_i,           // chip select 1, high active
    input  wire logic              chip_sel2_n_i,         // chip select 2, low active
    input  wire logic              advance_or_load_i,     // high advance, low load
    input  wire logic              read_not_write_i,      // high read, low write
    input  wire logic              byte_write_lane_a_n_i, // lane a write enable
    input  wire logic              byte_write_lane_b_n_i, // lane b write enable
    input  wire logic              output_drive_n_i,      // async output enable
    input  wire logic              linear_order_n_i,      // static burst order pin
    input  wire logic              snooze_request_i,      // async snooze request
    input  wire logic [ADDR_W-1:0] address_i,             // external word address
    input  wire logic [LANE_W-1:0] data_lane_a_i,         // lane a pin level
    input  wire logic [LANE_W-1:0] data_lane_b_i,         // lane b pin level
    output logic      [LANE_W-1:0] data_lane_a_o,         // lane a read data
    output logic      [LANE_W-1:0] data_lane_b_o,         // lane b read data
    output logic                   data_lane_a_oe_o,      // lane a drive enable
    output logic                   data_lane_b_oe_o,      // lane b drive enable
    output logic                   snooze_active_o        // device is in snooze
);
    import fbsp_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    logic [FBSP_SYNC_DEPTH-1:0] snz_sync_ff;
    logic [FBSP_SYNC_DEPTH-1:0] ord_sync_ff;
    logic                       snooze_ff;
    logic                       ord_n_ff;
    fbsp_op_t                   op_ff;
    logic [ADDR_W-1:0]          upper_ff;
    logic                       oe_ff;
    logic                       wr_pend_ff;
    logic [ADDR_W-1:0]          wr_addr_ff;
    logic [FBSP_LANES-1:0]      wr_be_ff;
    logic [LANE_W-1:0]          rd_data_ff [FBSP_LANES];
    logic [LANE_W-1:0]          wr_data    [FBSP_LANES];
    logic [FBSP_LANES-1:0]      be_now;
    logic                       en;
    logic                       sel;
    logic                       load;
    logic                       step;
    logic [FBSP_BURST_W-1:0]    nxt_low;
    logic [ADDR_W-1:0]          acc_addr;
    fbsp_op_t                   acc_op;
    logic                       acc_valid;

    // async pins pass three flops; a change counts once stages two and three agree
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            snz_sync_ff <= '0;
            ord_sync_ff <= '1;
        end else begin
            snz_sync_ff <= {snz_sync_ff[FBSP_SYNC_DEPTH-2:0], snooze_request_i};
            ord_sync_ff <= {ord_sync_ff[FBSP_SYNC_DEPTH-2:0], linear_order_n_i};
        end
    end

    // filtered snooze level; the sync delay makes entry and exit take four edges after the pin changes
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            snooze_ff <= FBSP_SNZ_RST;
        end else if (snz_sync_ff[1] == snz_sync_ff[2]) begin
            snooze_ff <= snz_sync_ff[2];
        end
    end

    // static order strap, defaults to interleaved like the pull-up
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ord_n_ff <= FBSP_ORD_RST;
        end else if (ord_sync_ff[1] == ord_sync_ff[2]) begin
            ord_n_ff <= ord_sync_ff[2];
        end
    end

    // command decode; held edges change nothing, snoozing edges only clear burst, drive and write state
    assign en     = clock_hold_n_i == 1'b0 && !snooze_ff;
    assign sel    = !chip_sel0_n_i && chip_sel1_i && !chip_sel2_n_i;
    assign load   = en && !advance_or_load_i && sel;
    assign step   = en && advance_or_load_i && op_ff != FBSP_OP_DESEL;
    assign be_now = {!byte_write_lane_b_n_i, !byte_write_lane_a_n_i};

    fbsp_burst_ctr #(
        .CNT_W (FBSP_BURST_W)
    ) u_burst (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (load),
        .step_i    (step),
        .linear_i  (!ord_n_ff),
        .start_i   (address_i[FBSP_BURST_W-1:0]),
        .nxt_low_o (nxt_low)
    );

    // address and operation of this edge's array access
    always_comb begin
        acc_addr  = address_i;
        acc_op    = read_not_write_i ? FBSP_OP_READ : FBSP_OP_WRITE;
        acc_valid = load;
        if (step) begin
            acc_addr  = {upper_ff[ADDR_W-1:FBSP_BURST_W], nxt_low};
            acc_op    = op_ff;
            acc_valid = 1'b1;
        end
    end

    // burst type and upper address held from the begin cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || (snooze_ff && clock_hold_n_i == 1'b0) || snooze_ff) begin
            op_ff    <= FBSP_OP_DESEL;
            upper_ff <= '0;
        end else if (en && !advance_or_load_i) begin
            op_ff    <= sel ? acc_op : FBSP_OP_DESEL;
            upper_ff <= address_i;
        end
    end

    // output drive: only reads drive; writes and deselects float the pins
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || snooze_ff) begin
            oe_ff <= 1'b0;
        end else if (en) begin
            oe_ff <= acc_valid && acc_op == FBSP_OP_READ;
        end
    end

    // late write: address and lane enables now, data at the next live edge
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || snooze_ff) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            wr_be_ff   <= '0;
        end else if (en) begin
            wr_pend_ff <= acc_valid && acc_op == FBSP_OP_WRITE && |be_now;
            wr_addr_ff <= acc_addr;
            wr_be_ff   <= be_now;
        end
    end

    assign wr_data[0] = data_lane_a_i;
    assign wr_data[1] = data_lane_b_i;

    // one array and read register per lane; a read of the address being
    // written this edge sees the new byte, so read after write needs no gap
    for (genvar g = 0; g < FBSP_LANES; g++) begin : g_lane
        logic [LANE_W-1:0] mem [DEPTH];
        logic              hit;

        assign hit = wr_pend_ff && wr_be_ff[g] && wr_addr_ff == acc_addr;

        always_ff @(posedge mclk_i) begin
            if (en && wr_pend_ff && wr_be_ff[g]) begin
                mem[wr_addr_ff] <= wr_data[g];
            end
        end

        always_ff @(posedge mclk_i) begin
            if (sys_rst_i) begin
                rd_data_ff[g] <= '0;
            end else if (en && acc_valid && acc_op == FBSP_OP_READ) begin
                rd_data_ff[g] <= hit ? wr_data[g] : mem[acc_addr];
            end
        end
    end

    assign data_lane_a_o = rd_data_ff[0];
    assign data_lane_b_o = rd_data_ff[1];

    // output_drive_n gates the registered enable without a clock
    assign data_lane_a_oe_o = oe_ff && !output_drive_n_i;
    assign data_lane_b_oe_o = oe_ff && !output_drive_n_i;
    assign snooze_active_o  = snooze_ff;

    // helper: low pair of the last access and steps since begin
    logic [FBSP_BURST_W-1:0] last_low_ff;
    logic [FBSP_BURST_W-1:0] start_low_ff;
    logic [2:0]              nsteps_ff;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            last_low_ff  <= '0;
            start_low_ff <= '0;
            nsteps_ff    <= '0;
        end else if (load) begin
            last_low_ff  <= address_i[FBSP_BURST_W-1:0];
            start_low_ff <= address_i[FBSP_BURST_W-1:0];
            nsteps_ff    <= '0;
        end else if (step) begin
            last_low_ff  <= acc_addr[FBSP_BURST_W-1:0];
            nsteps_ff    <= nsteps_ff + 3'h1;
        end
    end

    property p_snz_desel;
        @(posedge mclk_i) disable iff (sys_rst_i)
        snooze_ff |=> op_ff == FBSP_OP_DESEL && !wr_pend_ff;
    endproperty
    a_snz_desel: assert property (p_snz_desel) else $error("snooze not deselected");

    property p_snz_hiz;
        @(posedge mclk_i) disable iff (sys_rst_i)
        snooze_ff && $past(snooze_ff) |-> !data_lane_a_oe_o && !data_lane_b_oe_o;
    endproperty
    a_snz_hiz: assert property (p_snz_hiz) else $error("pins driven in snooze");

    property p_wake_delay;
        @(posedge mclk_i) disable iff (sys_rst_i)
        $fell(snooze_request_i) && snooze_ff |-> snooze_ff [*2];
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("woke too early");

    property p_sleep_delay;
        @(posedge mclk_i) disable iff (sys_rst_i)
        $rose(snooze_request_i) && !snooze_ff |-> !snooze_ff [*2];
    endproperty
    a_sleep_delay: assert property (p_sleep_delay) else $error("slept too early");

    property p_linear_step;
        @(posedge mclk_i) disable iff (sys_rst_i)
        step && !ord_n_ff |=> last_low_ff == $past(last_low_ff) + 2'h1;
    endproperty
    a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

    property p_wrap;
        @(posedge mclk_i) disable iff (sys_rst_i)
        step && nsteps_ff == 3'h3 |=> last_low_ff == start_low_ff;
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst did not wrap");

    property p_read_drive;
        @(posedge mclk_i) disable iff (sys_rst_i)
        load && read_not_write_i |=> oe_ff;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");

    property p_write_pend;
        @(posedge mclk_i) disable iff (sys_rst_i)
        load && !read_not_write_i |=> !oe_ff && wr_pend_ff == |$past(be_now);
    endproperty
    a_write_pend: assert property (p_write_pend) else $error("write start wrong");

    property p_hold;
        @(posedge mclk_i) disable iff (sys_rst_i)
        clock_hold_n_i && !snooze_ff |=> $stable(op_ff) && $stable(oe_ff) && $stable(wr_pend_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved on hold");

    property p_inter_step;
        @(posedge mclk_i) disable iff (sys_rst_i)
        step && ord_n_ff |=> last_low_ff == (start_low_ff ^ nsteps_ff[1:0]);
    endproperty
    a_inter_step: assert property (p_inter_step) else $error("interleaved step wrong");

    property p_desel_float;
        @(posedge mclk_i) disable iff (sys_rst_i)
        en && !advance_or_load_i && !sel |=> !oe_ff && !wr_pend_ff && op_ff == FBSP_OP_DESEL;
    endproperty
    a_desel_float: assert property (p_desel_float) else $error("deselect not floating");

    property p_abort_quiet;
        @(posedge mclk_i) disable iff (sys_rst_i)
        en && acc_valid && acc_op == FBSP_OP_WRITE && be_now == '0 |=> !wr_pend_ff && !oe_ff;
    endproperty
    a_abort_quiet: assert property (p_abort_quiet) else $error("write abort not quiet");

    property p_write_float;
        @(posedge mclk_i) disable iff (sys_rst_i)
        wr_pend_ff |-> !data_lane_a_oe_o && !data_lane_b_oe_o;
    endproperty
    a_write_float: assert property (p_write_float) else $error("pins driven in write");

    property p_reset_hiz;
        @(posedge mclk_i) sys_rst_i |=> !oe_ff && !wr_pend_ff;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("driving after reset");
endmodule : fbsp_sram_port

/* fbsp_pkg.sv */
// constants and types shared by the flow-through burst sram port
package fbsp_pkg;
    // operation chosen by the last begin-burst cycle
    typedef enum logic [1:0] {
        FBSP_OP_DESEL = 2'b00,
        FBSP_OP_READ  = 2'b01,
        FBSP_OP_WRITE = 2'b10
    } fbsp_op_t;

    localparam int          FBSP_LANES      = 2;     // data lane a and b
    localparam int          FBSP_BURST_W    = 2;     // burst counter width
    localparam int          FBSP_SYNC_DEPTH = 3;     // pin synchroniser stages
    localparam int          FBSP_SNZ_MIN_CYC = 2;    // snooze entry/exit, in cycles
    localparam logic [1:0]  FBSP_CNT_RST    = 2'h0;  // burst counter after reset
    localparam logic        FBSP_SNZ_RST    = 1'b0;  // not snoozing after reset
    localparam logic        FBSP_ORD_RST    = 1'b1;  // pulled high: interleaved
endpackage : fbsp_pkg

/* fbsp_burst_ctr.sv */
// two-bit burst counter with linear or interleaved address order
`timescale 1ns/1ps
module fbsp_burst_ctr
    import fbsp_pkg::*;
#(
    parameter int CNT_W = FBSP_BURST_W
) (
    input  wire logic             mclk_i,     // system clock
    input  wire logic             sys_rst_i,  // synchronous reset, active high
    input  wire logic             load_i,     // begin burst: take start value
    input  wire logic             step_i,     // continue burst: advance
    input  wire logic             linear_i,   // 1 = linear, 0 = interleaved
    input  wire logic [CNT_W-1:0] start_i,    // external low address pair
    output logic      [CNT_W-1:0] nxt_low_o   // low address pair of next step
);
    logic [CNT_W-1:0] start_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // counter wraps by its own width, so every fourth step is the start again
    assign nxt_cnt = cnt_ff + CNT_W'(1);

    // linear adds the count, interleaved xors it
    assign nxt_low_o = linear_i ? CNT_W'(start_ff + nxt_cnt) : (start_ff ^ nxt_cnt);

    // start value and step count
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            start_ff <= CNT_W'(FBSP_CNT_RST);
            cnt_ff   <= CNT_W'(FBSP_CNT_RST);
        end else if (load_i) begin
            start_ff <= start_i;
            cnt_ff   <= CNT_W'(FBSP_CNT_RST);
        end else if (step_i) begin
            cnt_ff   <= nxt_cnt;
        end
    end
endmodule : fbsp_burst_ctr

/* fbsp_ctl_model.sv */
// controller side of the data pins: late write data and pin resolution
`timescale 1ns/1ps
module fbsp_ctl_model #(
    parameter int LANE_W = 9  // bits per lane
) (
    input  wire logic                ctl_drive_i, // write data phase
    input  wire logic [2*LANE_W-1:0] ctl_data_i,  // write data {a,b}
    input  wire logic [1:0]          dev_oe_i,    // device enables {a,b}
    input  wire logic [2*LANE_W-1:0] dev_data_i,  // device data {a,b}
    output logic      [2*LANE_W-1:0] pin_o        // resolved pins {a,b}
);
    logic [2*LANE_W-1:0] last = '0;
    // no pull on the pins, so a floating lane shows the inverse of its last level
    always @* begin
        for (int l = 0; l < 2; l++) begin
            if (ctl_drive_i && dev_oe_i[l]) begin
                pin_o[l*LANE_W +: LANE_W] = {LANE_W{1'bx}};
            end else if (ctl_drive_i) begin
                pin_o[l*LANE_W +: LANE_W] = ctl_data_i[l*LANE_W +: LANE_W];
                last[l*LANE_W +: LANE_W]  = ctl_data_i[l*LANE_W +: LANE_W];
            end else if (dev_oe_i[l]) begin
                pin_o[l*LANE_W +: LANE_W] = dev_data_i[l*LANE_W +: LANE_W];
                last[l*LANE_W +: LANE_W]  = dev_data_i[l*LANE_W +: LANE_W];
            end else begin
                pin_o[l*LANE_W +: LANE_W] = ~last[l*LANE_W +: LANE_W];
            end
        end
    end
endmodule : fbsp_ctl_model

/* tb_top.sv */
// self-checking bench for the flow-through burst sram port
`timescale 1ns/1ps
module tb_top;
    import fbsp_pkg::*;
    localparam logic [2:0] SEL_ON = 3'b010; // {sel0_n, sel1, sel2_n} active
    logic        mclk_i, sys_rst_i, hold_n, adv, rnw, oe_n, ord_n, snz;
    logic        drv, pend, cur_wr, oe_a, oe_b, snz_act;
    logic [2:0]  sel;
    logic [1:0]  lane_wr_n;
    logic [3:0]  addr;
    logic [8:0]  q_a, q_b;
    logic [17:0] ctl_d, pend_d, pins, exp_mem [16];
    int          errors, tests_run;

    fbsp_sram_port #(.ADDR_W(4), .LANE_W(9)) u_fbsp_sram_port (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clock_hold_n_i(hold_n),
        .chip_sel0_n_i(sel[2]), .chip_sel1_i(sel[1]), .chip_sel2_n_i(sel[0]),
        .advance_or_load_i(adv), .read_not_write_i(rnw),
        .byte_write_lane_a_n_i(lane_wr_n[1]), .byte_write_lane_b_n_i(lane_wr_n[0]),
        .output_drive_n_i(oe_n), .linear_order_n_i(ord_n), .snooze_request_i(snz),
        .address_i(addr), .data_lane_a_i(pins[17:9]), .data_lane_b_i(pins[8:0]),
        .data_lane_a_o(q_a), .data_lane_b_o(q_b), .data_lane_a_oe_o(oe_a),
        .data_lane_b_oe_o(oe_b), .snooze_active_o(snz_act));
    fbsp_ctl_model #(.LANE_W(9)) u_fbsp_ctl_model (
        .ctl_drive_i(drv), .ctl_data_i(ctl_d), .dev_oe_i({oe_a, oe_b}),
        .dev_data_i({q_a, q_b}), .pin_o(pins));

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] k, input logic lin);
        return lin ? s + k : s ^ k;
    endfunction : nxt
    task automatic wr_exp(input logic [3:0] ad, input logic [1:0] bw, input logic [17:0] wd);
        if (!bw[1]) exp_mem[ad][17:9] = wd[17:9];
        if (!bw[0]) exp_mem[ad][8:0] = wd[8:0];
    endtask : wr_exp
    // one bus cycle; write data follows one live edge after its command
    task automatic op(input logic h, input logic a, input logic [2:0] s, input logic r,
                      input logic [3:0] ad, input logic [1:0] bw, input logic [17:0] wd);
        @(negedge mclk_i);
        hold_n = h;
        adv = a;
        sel = s;
        rnw = r;
        addr = ad;
        lane_wr_n = bw;
        drv = pend;
        ctl_d = pend_d;
        if (!h) begin
            if (!a) cur_wr = (s == SEL_ON) && !r;
            pend = cur_wr;
            pend_d = wd;
        end
    endtask : op
    // look at the pins once the edge has landed
    task automatic see(input logic [1:0] oe_exp, input logic [17:0] d_exp);
        @(posedge mclk_i);
        #1;
        chk({16'h0, oe_a, oe_b}, {16'h0, oe_exp});
        if (oe_exp == 2'b11) chk({q_a, q_b}, d_exp);
    endtask : see

    task automatic t_burst(input logic lin);
        logic [3:0]  b, ad;
        logic [17:0] wd;
        b = lin ? 4'h5 : 4'hA;
        ord_n = !lin;
        repeat (6) @(negedge mclk_i); // order pin passes a synchroniser
        for (int k = 0; k < 5; k++) begin // fifth access wraps to the start
            wd = {lin, 13'h0A5A, 4'(k)};
            ad = {b[3:2], nxt(b[1:0], 2'(k), lin)};
            op(1'b0, k != 0, k != 0 ? 3'b101 : SEL_ON, k != 0, k != 0 ? ~b : b, 2'b00, wd);
            wr_exp(ad, 2'b00, wd);
        end
        for (int k = 0; k < 5; k++) begin
            ad = {b[3:2], nxt(b[1:0], 2'(k), lin)};
            op(1'b0, k != 0, k != 0 ? 3'b101 : SEL_ON, k == 0, k != 0 ? ~b : b, 2'b11, 18'h0);
            see(2'b11, exp_mem[ad]);
        end
        op(1'b0, 1'b0, 3'b101, 1'b1, 4'h0, 2'b11, 18'h0);
        $display("burst test done, linear %0b", lin);
    endtask : t_burst

    task automatic t_lanes;
        op(1'b0, 1'b0, SEL_ON, 1'b0, 4'h0, 2'b00, 18'h1E0F3);
        wr_exp(4'h0, 2'b00, 18'h1E0F3);
        see(2'b00, 18'h0);
        op(1'b0, 1'b0, SEL_ON, 1'b0, 4'h0, 2'b10, 18'h3FE00);
        wr_exp(4'h0, 2'b10, 18'h3FE00);
        op(1'b0, 1'b0, SEL_ON, 1'b0, 4'h0, 2'b11, 18'h3FFFF);
        see(2'b00, 18'h0);
        op(1'b0, 1'b0, SEL_ON, 1'b1, 4'h0, 2'b11, 18'h0);
        see(2'b11, exp_mem[0]);
        $display("lane test done");
    endtask : t_lanes

    task automatic t_dummy_hold;
        @(negedge mclk_i) oe_n = 1'b1;
        op(1'b0, 1'b0, SEL_ON, 1'b1, 4'h5, 2'b11, 18'h0);
        see(2'b00, 18'h0);
        @(negedge mclk_i) oe_n = 1'b0;
        op(1'b0, 1'b1, SEL_ON, 1'b1, 4'h5, 2'b11, 18'h0);
        see(2'b11, exp_mem[4]);
        op(1'b1, 1'b1, SEL_ON, 1'b1, 4'h5, 2'b11, 18'h0);
        see(2'b11, exp_mem[4]);
        // no clock edge between the change and the look: the gate is async
        @(negedge mclk_i) oe_n = 1'b1;
        #1 chk({16'h0, oe_a, oe_b}, 18'h0);
        @(negedge mclk_i) oe_n = 1'b0;
        op(1'b0, 1'b1, SEL_ON, 1'b1, 4'h5, 2'b11, 18'h0);
        see(2'b11, exp_mem[7]);
        $display("dummy read and hold test done");
    endtask : t_dummy_hold

    task automatic t_desel;
        for (int i = 0; i < 3; i++) begin
            op(1'b0, 1'b0, SEL_ON, 1'b1, 4'h0, 2'b11, 18'h0);
            see(2'b11, exp_mem[0]);
            op(1'b0, 1'b0, SEL_ON ^ (3'b100 >> i), 1'b1, 4'h0, 2'b11, 18'h0);
            see(2'b00, 18'h0);
            op(1'b0, 1'b1, SEL_ON, 1'b1, 4'h0, 2'b11, 18'h0);
            see(2'b00, 18'h0);
        end
        $display("deselect test done");
    endtask : t_desel

    task automatic t_snooze;
        int n;
        op(1'b0, 1'b0, SEL_ON, 1'b1, 4'h0, 2'b11, 18'h0);
        see(2'b11, exp_mem[0]);
        @(negedge mclk_i) snz = 1'b1;
        @(posedge mclk_i) #1 chk({17'h0, snz_act}, 18'h0);
        n = 0;
        while (snz_act !== 1'b1 && n < 4) begin
            @(posedge mclk_i) #1 n++;
        end
        chk({17'h0, snz_act}, 18'h1);
        op(1'b0, 1'b0, SEL_ON, 1'b0, 4'h0, 2'b00, 18'h0);
        op(1'b0, 1'b0, SEL_ON, 1'b1, 4'h0, 2'b11, 18'h0);
        see(2'b00, 18'h0);
        @(negedge mclk_i) snz = 1'b0;
        @(posedge mclk_i) #1 chk({17'h0, snz_act}, 18'h1);
        n = 0;
        while (snz_act !== 1'b0 && n < 4) begin
            @(posedge mclk_i) #1 n++;
        end
        op(1'b0, 1'b0, SEL_ON, 1'b1, 4'h0, 2'b11, 18'h0);
        see(2'b11, exp_mem[0]);
        $display("snooze test done");
    endtask : t_snooze

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // 200 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // run needs under a hundred cycles; this limit only cuts a hang
    initial begin
        repeat (5000) @(posedge mclk_i);
        errors++;
        $display("watchdog expired");
        end_of_test();
    end
    initial begin
        errors = 0;
        tests_run = 0;
        sys_rst_i = 1'b1;
        hold_n = 1'b0;
        adv = 1'b0;
        sel = 3'b101;
        rnw = 1'b1;
        lane_wr_n = 2'b11;
        addr = 4'h0;
        oe_n = 1'b0;
        ord_n = 1'b1;
        snz = 1'b0;
        drv = 1'b0;
        ctl_d = 18'h0;
        pend = 1'b0;
        pend_d = 18'h0;
        cur_wr = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk({16'h0, oe_a, oe_b}, 18'h0);
        sys_rst_i = 1'b0;
        t_burst(1'b1);
        t_burst(1'b0);
        t_lanes();
        t_dummy_hold();
        t_desel();
        t_snooze();
        end_of_test();
    end
endmodule : tb_top
